// ==== design/sio_pkg.sv ====
// Constants, field layouts and carrier types for the configuration register bank.
// Assumes a single 40 MHz clock and a host that enters configuration mode elsewhere.
//
// Summary of operation
// - In configuration mode, write an index to the select port, then use the data port.
// - Power-up loads defaults; an ordinary reset leaves register contents unchanged.
// - Parallel-and-lock register sits at index 01h and powers up as 9Fh.
// - Parallel base: 00 off, 01 3BCh, 10 378h, 11 278h.
// - Bit 2 high powers the parallel port; low puts it in low power.
// - Bit 4 high drives interrupts active high; low drives active low, floats inactive.
// - In ECP or EPP modes the parallel interrupt is always active low, floating.
// - Bits 6:5 choose third and fourth serial slot addresses.
// - Lock bit high permits access; once cleared only hard or power-up reset sets it.
// - Serial-setup register sits at index 02h and powers up as DCh.
// - Bits 1:0 place the primary UART: 3F8h, 2F8h, slot three, slot four.
// - Bit 2 high enables the primary UART.
// - Bit 3 low puts the primary UART in power-down.
// - Bits 5:4 place the secondary UART alike; default 2F8h.
// - Bit 6 high enables the secondary UART.
// - Bit 7 low puts the secondary UART in power-down.
// - Floppy-options register sits at index 03h and powers up as 78h.
// - Bit 1 selects normal or enhanced floppy mode 2.
// - Bits 3 and 4 map rate selects to rate pins; ignored when bit 1 set.
// - Options 00 copy, option 0 swaps 500/250 codes, both set makes inputs.
// - Bits 6:5 choose the floppy interface style; 11 is the default.
package sio_pkg;

   // Host port addresses
   localparam logic [15:0] SEL_PORT  = 16'h03F0;
   localparam logic [15:0] DATA_PORT = 16'h03F1;

   // Register indices, power-up values and the floppy write mask
   localparam logic [7:0]  IDX_PAR    = 8'h01;
   localparam logic [7:0]  IDX_SER    = 8'h02;
   localparam logic [7:0]  IDX_FLP    = 8'h03;
   localparam logic [7:0]  PAR_RST    = 8'h9F;
   localparam logic [7:0]  SER_RST    = 8'hDC;
   localparam logic [7:0]  FLP_RST    = 8'h78;
   localparam logic [7:0]  FLP_WMASK  = 8'hFE;
   localparam logic [7:0]  IDX_RST    = 8'h00;

   // Parallel-and-lock field positions
   localparam int PP_ADDR_LSB = 0;
   localparam int PP_PWR_BIT  = 2;
   localparam int PP_MODE_BIT = 3;
   localparam int IRQ_POL_BIT = 4;
   localparam int SLOT_LSB    = 5;
   localparam int LOCK_BIT    = 7;

   // Serial-setup field positions
   localparam int U1_ADDR_LSB = 0;
   localparam int U1_EN_BIT   = 2;
   localparam int U1_PWR_BIT  = 3;
   localparam int U2_ADDR_LSB = 4;
   localparam int U2_EN_BIT   = 6;
   localparam int U2_PWR_BIT  = 7;

   // Floppy-options field positions
   localparam int ENH_BIT     = 1;
   localparam int PSEL_LO_BIT = 2;
   localparam int OPT0_BIT    = 3;
   localparam int OPT1_BIT    = 4;
   localparam int STYLE_LSB   = 5;
   localparam int PSEL_HI_BIT = 7;

   // Decoded addresses
   localparam logic [15:0] PP_ADDR_A = 16'h03BC;
   localparam logic [15:0] PP_ADDR_B = 16'h0378;
   localparam logic [15:0] PP_ADDR_C = 16'h0278;
   localparam logic [15:0] NO_ADDR   = 16'h0000;
   localparam logic [15:0] UART_A    = 16'h03F8;
   localparam logic [15:0] UART_B    = 16'h02F8;
   localparam logic [15:0] SLOT3_0   = 16'h0338;
   localparam logic [15:0] SLOT4_0   = 16'h0238;
   localparam logic [15:0] SLOT3_1   = 16'h03E8;
   localparam logic [15:0] SLOT4_1   = 16'h02E8;
   localparam logic [15:0] SLOT3_2   = 16'h02E8;
   localparam logic [15:0] SLOT4_2   = 16'h02E0;
   localparam logic [15:0] SLOT3_3   = 16'h0220;
   localparam logic [15:0] SLOT4_3   = 16'h0228;

   // Extended parallel mode codes of the extended-setup register
   localparam logic [1:0]  EXT_EPP = 2'h1;
   localparam logic [1:0]  EXT_ECP = 2'h2;

   // Role of the multiplexed pin
   typedef enum logic [1:0] {
      PIN_DRIVE_SENSE = 2'b00,
      PIN_EXTRA_ADDR  = 2'b01,
      PIN_IRQ_TWO     = 2'b10,
      PIN_IRQ_TWO_ALT = 2'b11
   } sio_pin_role_t;

   // One tri-state pin drive
   typedef struct packed {
      logic out;
      logic oe;
   } sio_pin_t;

   // One UART's placement
   typedef struct packed {
      logic [15:0] base;
      logic        enable;
      logic        powered;
   } sio_uart_t;

   // Rate mapper state
   typedef struct packed {
      logic [1:0] pinOut;
      logic [1:0] pinOe;
   } sio_rate_t;

   // Whole state of the register bank
   typedef struct packed {
      logic [7:0]    index;
      logic [7:0]    parallelAndLockConfig;
      logic [7:0]    serialPortsConfig;
      logic [7:0]    floppyInterfaceOptions;
      logic [7:0]    rdData;
      logic          rdValid;
      logic [15:0]   ppBase;
      logic          ppPowered;
      logic          ppPrinterMode;
      logic [15:0]   slotThree;
      logic [15:0]   slotFour;
      sio_uart_t     uartOne;
      sio_uart_t     uartTwo;
      logic          enhancedMode;
      logic [1:0]    interfaceStyle;
      sio_pin_t      serialIrqA;
      sio_pin_t      serialIrqB;
      sio_pin_t      floppyIrq;
      sio_pin_t      parallelIrq;
      sio_pin_t      muxPin;
      logic          driveTwoSense;
   } sio_state_t;

endpackage

// ==== design/sio_rate_map.sv ====
// Maps the floppy data-rate select bits onto the two rate pins.
// Assumes the rate select bits come from the floppy controller on the same clock.
`timescale 1ns/1ps
module sio_rate_map (
   // Clock and control
   input  wire logic             clk,
   input  wire logic             sys_rst,
   input  wire logic             ce,
   // Mapping options
   input  wire logic [1:0]       rateSel,
   input  wire logic             optZero,
   input  wire logic             optOne,
   input  wire logic             enhanced,
   // Pin drive
   output sio_pkg::sio_rate_t    ratePins
);

   sio_pkg::sio_rate_t st;
   sio_pkg::sio_rate_t next_st;
   logic               o0;
   logic               o1;

   ////////////////////////////////////////////////////////////////////////////////
   // Options are don't-care in enhanced mode
   always_comb begin
      o0 = optZero & ~enhanced;
      o1 = optOne & ~enhanced;
      next_st = st;
      if (o0 && o1) begin
         next_st.pinOut = 2'h0;
         next_st.pinOe  = 2'h0;
      end else if (o0) begin
         next_st.pinOut = {rateSel[1] ^ ~rateSel[0], rateSel[0]};
         next_st.pinOe  = 2'h3;
      end else begin
         next_st.pinOut = rateSel;
         next_st.pinOe  = 2'h3;
      end
   end

   // Register the pin drive
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         st <= '0;
      end else if (ce) begin
         st <= next_st;
      end
   end

   assign ratePins = st;

endmodule // sio_rate_map

// ==== design/sio_config_regs.sv ====
// Configuration register bank for parallel, serial and floppy setup.
// Assumes configuration-mode entry and exit are decoded outside and given as a level.
`timescale 1ns/1ps
module sio_config_regs (
   // Clock and control
   input  wire logic                clk,
   input  wire logic                sys_rst,
   input  wire logic                ce,
   input  wire logic                hardRst,
   // Host port
   input  wire logic                cfgMode,
   input  wire logic [15:0]         hostAddr,
   input  wire logic                hostWrStb,
   input  wire logic                hostRdStb,
   input  wire logic [7:0]          hostWrData,
   output logic [7:0]               hostRdData,
   output logic                     hostRdValid,
   // Parallel port setup
   output logic [15:0]              ppBase,
   output logic                     ppPowered,
   output logic                     ppPrinterMode,
   input  wire logic [1:0]          ppExtMode,
   output logic                     cfgUnlocked,
   // Serial setup
   output logic [15:0]              slotThree,
   output logic [15:0]              slotFour,
   output sio_pkg::sio_uart_t       uartOne,
   output sio_pkg::sio_uart_t       uartTwo,
   // Floppy setup
   output logic                     enhancedMode,
   output logic [1:0]               interfaceStyle,
   input  wire logic [1:0]          rateSel,
   output sio_pkg::sio_rate_t       ratePins,
   // Interrupt requests and pins
   input  wire logic                serialReqA,
   input  wire logic                serialReqB,
   input  wire logic                floppyReq,
   input  wire logic                parallelReq,
   output sio_pkg::sio_pin_t        serialIrqA,
   output sio_pkg::sio_pin_t        serialIrqB,
   output sio_pkg::sio_pin_t        floppyIrq,
   output sio_pkg::sio_pin_t        parallelIrq,
   // Multiplexed pin
   input  wire logic                muxPinIn,
   input  wire logic                extraAddrHit,
   output sio_pkg::sio_pin_t        muxPin,
   output logic                     driveTwoSense
);

   sio_pkg::sio_state_t st;
   sio_pkg::sio_state_t next_st;
   sio_pkg::sio_pin_role_t role;
   logic                unlocked;
   logic                dataWr;
   logic                dataRd;
   logic                extIrq;
   logic [7:0]          par;
   logic [7:0]          ser;
   logic [7:0]          flp;

   ////////////////////////////////////////////////////////////////////////////////
   // Helpers

   // Drive one interrupt pin for the chosen polarity
   function automatic sio_pkg::sio_pin_t irqDrive(input logic req, input logic highPol);
      sio_pkg::sio_pin_t p;
      if (highPol) begin
         p.out = req;
         p.oe  = 1'b1;
      end else begin
         p.out = 1'b0;
         p.oe  = req;
      end
      return p;
   endfunction

   // Place one UART from its two-bit code
   function automatic logic [15:0] uartAddr(input logic [1:0] code, input logic [15:0] s3,
                                            input logic [15:0] s4);
      logic [15:0] a;
      unique case (code)
         2'h0: a = sio_pkg::UART_A;
         2'h1: a = sio_pkg::UART_B;
         2'h2: a = s3;
         2'h3: a = s4;
      endcase
      return a;
   endfunction

   ////////////////////////////////////////////////////////////////////////////////
   // Decode of the current registers
   always_comb begin
      par      = st.parallelAndLockConfig;
      ser      = st.serialPortsConfig;
      flp      = st.floppyInterfaceOptions;
      unlocked = par[sio_pkg::LOCK_BIT];
      dataWr   = cfgMode & hostWrStb & (hostAddr == sio_pkg::DATA_PORT) & unlocked;
      dataRd   = cfgMode & hostRdStb & (hostAddr == sio_pkg::DATA_PORT);
      extIrq   = ~par[sio_pkg::PP_MODE_BIT] &
                 ((ppExtMode == sio_pkg::EXT_EPP) | (ppExtMode == sio_pkg::EXT_ECP));
      role     = sio_pkg::sio_pin_role_t'({flp[sio_pkg::PSEL_HI_BIT], flp[sio_pkg::PSEL_LO_BIT]});
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Next state
   always_comb begin
      next_st         = st;
      next_st.rdValid = 1'b0;

      // Index select port write
      if (cfgMode && hostWrStb && hostAddr == sio_pkg::SEL_PORT) begin
         next_st.index = hostWrData;
      end

      // Data port write, blocked by the lock
      if (dataWr) begin
         unique case (st.index)
            sio_pkg::IDX_PAR: next_st.parallelAndLockConfig = hostWrData;
            sio_pkg::IDX_SER: next_st.serialPortsConfig     = hostWrData;
            sio_pkg::IDX_FLP: next_st.floppyInterfaceOptions =
                                 hostWrData & sio_pkg::FLP_WMASK;
            default: ;
         endcase
      end

      // Hard reset only restores the lock bit and the index
      if (hardRst) begin
         next_st.parallelAndLockConfig[sio_pkg::LOCK_BIT] = 1'b1;
         next_st.index = sio_pkg::IDX_RST;
      end

      // Data port read answers the following cycle
      if (dataRd) begin
         next_st.rdValid = 1'b1;
         if (!unlocked) begin
            next_st.rdData = 8'h00;
         end else begin
            unique case (st.index)
               sio_pkg::IDX_PAR: next_st.rdData = par;
               sio_pkg::IDX_SER: next_st.rdData = ser;
               sio_pkg::IDX_FLP: next_st.rdData = flp;
               default:          next_st.rdData = 8'h00;
            endcase
         end
      end

      // Parallel port placement and modes
      unique case (par[sio_pkg::PP_ADDR_LSB +: 2])
         2'h0: next_st.ppBase = sio_pkg::NO_ADDR;
         2'h1: next_st.ppBase = sio_pkg::PP_ADDR_A;
         2'h2: next_st.ppBase = sio_pkg::PP_ADDR_B;
         2'h3: next_st.ppBase = sio_pkg::PP_ADDR_C;
      endcase
      next_st.ppPowered     = par[sio_pkg::PP_PWR_BIT];
      next_st.ppPrinterMode = par[sio_pkg::PP_MODE_BIT];

      // Third and fourth serial slots
      unique case (par[sio_pkg::SLOT_LSB +: 2])
         2'h0: begin
            next_st.slotThree = sio_pkg::SLOT3_0;
            next_st.slotFour  = sio_pkg::SLOT4_0;
         end
         2'h1: begin
            next_st.slotThree = sio_pkg::SLOT3_1;
            next_st.slotFour  = sio_pkg::SLOT4_1;
         end
         2'h2: begin
            next_st.slotThree = sio_pkg::SLOT3_2;
            next_st.slotFour  = sio_pkg::SLOT4_2;
         end
         2'h3: begin
            next_st.slotThree = sio_pkg::SLOT3_3;
            next_st.slotFour  = sio_pkg::SLOT4_3;
         end
      endcase

      // UART placement, enable and power
      next_st.uartOne.base    = uartAddr(ser[sio_pkg::U1_ADDR_LSB +: 2], st.slotThree, st.slotFour);
      next_st.uartOne.enable  = ser[sio_pkg::U1_EN_BIT];
      next_st.uartOne.powered = ser[sio_pkg::U1_PWR_BIT];
      next_st.uartTwo.base    = uartAddr(ser[sio_pkg::U2_ADDR_LSB +: 2], st.slotThree, st.slotFour);
      next_st.uartTwo.enable  = ser[sio_pkg::U2_EN_BIT];
      next_st.uartTwo.powered = ser[sio_pkg::U2_PWR_BIT];

      // Floppy mode and interface style
      next_st.enhancedMode   = flp[sio_pkg::ENH_BIT];
      next_st.interfaceStyle = flp[sio_pkg::STYLE_LSB +: 2];

      // Interrupt pin polarity
      next_st.serialIrqA  = irqDrive(serialReqA, par[sio_pkg::IRQ_POL_BIT]);
      next_st.serialIrqB  = irqDrive(serialReqB, par[sio_pkg::IRQ_POL_BIT]);
      next_st.floppyIrq   = irqDrive(floppyReq, par[sio_pkg::IRQ_POL_BIT]);
      next_st.parallelIrq = irqDrive(parallelReq, par[sio_pkg::IRQ_POL_BIT] & ~extIrq);

      // Multiplexed pin role
      unique case (role)
         sio_pkg::PIN_DRIVE_SENSE: begin
            next_st.muxPin        = '0;
            next_st.driveTwoSense = muxPinIn;
         end
         sio_pkg::PIN_EXTRA_ADDR: begin
            next_st.muxPin.out = extraAddrHit;
            next_st.muxPin.oe  = 1'b1;
         end
         sio_pkg::PIN_IRQ_TWO, sio_pkg::PIN_IRQ_TWO_ALT: begin
            next_st.muxPin = next_st.parallelIrq;
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////////
   // State register; only the power-up reset loads defaults
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         st                        <= '0;
         st.parallelAndLockConfig  <= sio_pkg::PAR_RST;
         st.serialPortsConfig      <= sio_pkg::SER_RST;
         st.floppyInterfaceOptions <= sio_pkg::FLP_RST;
         st.index                  <= sio_pkg::IDX_RST;
      end else if (ce) begin
         st <= next_st;
      end
   end

   // Rate pin mapper
   sio_rate_map u_rate (
      .clk      (clk),
      .sys_rst  (sys_rst),
      .ce       (ce),
      .rateSel  (rateSel),
      .optZero  (st.floppyInterfaceOptions[sio_pkg::OPT0_BIT]),
      .optOne   (st.floppyInterfaceOptions[sio_pkg::OPT1_BIT]),
      .enhanced (st.floppyInterfaceOptions[sio_pkg::ENH_BIT]),
      .ratePins (ratePins)
   );

   // Outputs straight from the state register
   assign hostRdData     = st.rdData;
   assign hostRdValid    = st.rdValid;
   assign ppBase         = st.ppBase;
   assign ppPowered      = st.ppPowered;
   assign ppPrinterMode  = st.ppPrinterMode;
   assign cfgUnlocked    = st.parallelAndLockConfig[sio_pkg::LOCK_BIT];
   assign slotThree      = st.slotThree;
   assign slotFour       = st.slotFour;
   assign uartOne        = st.uartOne;
   assign uartTwo        = st.uartTwo;
   assign enhancedMode   = st.enhancedMode;
   assign interfaceStyle = st.interfaceStyle;
   assign serialIrqA     = st.serialIrqA;
   assign serialIrqB     = st.serialIrqB;
   assign floppyIrq      = st.floppyIrq;
   assign parallelIrq    = st.parallelIrq;
   assign muxPin         = st.muxPin;
   assign driveTwoSense  = st.driveTwoSense;

   ////////////////////////////////////////////////////////////////////////////////
   // Checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);

   index_write_a: assert property (ce && cfgMode && hostWrStb && hostAddr == sio_pkg::SEL_PORT && !hardRst
      |=> st.index == $past(hostWrData)) else $error("index not loaded");

   hard_reset_keep_a: assert property (ce && hardRst && !(cfgMode && hostWrStb)
      |=> $stable(st.serialPortsConfig) && cfgUnlocked) else $error("hard reset touched config");

   read_parallel_a: assert property (ce && dataRd && unlocked && st.index == sio_pkg::IDX_PAR
      |=> hostRdValid && hostRdData == $past(par)) else $error("bad parallel read");

   pp_base_a: assert property (ce && !sys_rst ##1 ce && $past(par[1:0]) == 2'h2 |-> ppBase == sio_pkg::PP_ADDR_B)
      else $error("bad parallel base");

   irq_pol_a: assert property (ce && !sys_rst && par[sio_pkg::IRQ_POL_BIT]
      |=> floppyIrq.oe && floppyIrq.out == $past(floppyReq))
      else $error("bad high polarity");

   pp_ext_irq_a: assert property (ce && extIrq |=> parallelIrq.out == 1'b0 && parallelIrq.oe == $past(parallelReq))
      else $error("extended mode irq not low");

   lock_hold_a: assert property (ce && !unlocked && !hardRst |=> !cfgUnlocked [*2] or (!cfgUnlocked ##1 hardRst))
      else $error("lock reopened");

   lock_block_a: assert property (ce && !unlocked && hostWrStb |=> $stable(st.serialPortsConfig))
      else $error("locked write landed");

   uart_one_en_a: assert property (ce && !sys_rst ##1 ce |-> uartOne.enable == $past(ser[sio_pkg::U1_EN_BIT]))
      else $error("bad uart enable");

   flp_reserved_a: assert property (st.floppyInterfaceOptions[0] == 1'b0)
      else $error("reserved bit set");

   lock_clear_c: cover property (ce && dataWr && st.index == sio_pkg::IDX_PAR && !hostWrData[7]);
   ext_irq_c:    cover property (ce && extIrq && parallelReq);
   serial_wr_c:  cover property (ce && dataWr && st.index == sio_pkg::IDX_SER);

endmodule // sio_config_regs

// ==== verification/tb_top.sv ====
// Self-checking bench for the configuration register bank.
// Assumes the bank alone on one 40 MHz clock, reached only through its host port.
`timescale 1ns/1ps
module tb_top;
   ////////////////////////////////////////////////////////////////////////////
   logic clk, sys_rst, ce, hardRst, cfgMode, hostWrStb, hostRdStb;
   logic serialReqA, serialReqB, floppyReq, parallelReq, muxPinIn, extraAddrHit;
   logic [15:0] hostAddr;
   logic [7:0]  hostWrData, hostRdData, d, v, s, f;
   logic [1:0]  ppExtMode, rateSel;
   logic        hostRdValid, ppPowered, cfgUnlocked, enhancedMode, ppPrinterMode, driveTwoSense;
   logic [15:0] ppBase, slotThree, slotFour;
   logic [1:0]  interfaceStyle;
   sio_pkg::sio_uart_t uartOne, uartTwo;
   sio_pkg::sio_rate_t ratePins;
   sio_pkg::sio_pin_t  floppyIrq, parallelIrq, serialIrqA, muxPin;
   int          mismatches, n_checks, cyc, seed, i, j, k;
   logic [15:0] ppt[4] = '{16'h0000, 16'h03BC, 16'h0378, 16'h0278};
   logic [15:0] s3t[4] = '{16'h0338, 16'h03E8, 16'h02E8, 16'h0220};
   logic [15:0] s4t[4] = '{16'h0238, 16'h02E8, 16'h02E0, 16'h0228};
   logic [1:0]  swp[4] = '{2'h2, 2'h1, 2'h0, 2'h3};

   sio_config_regs dut_u (.clk(clk), .sys_rst(sys_rst), .ce(ce), .hardRst(hardRst), .cfgMode(cfgMode),
      .hostAddr(hostAddr), .hostWrStb(hostWrStb), .hostRdStb(hostRdStb), .hostWrData(hostWrData),
      .hostRdData(hostRdData), .hostRdValid(hostRdValid), .ppBase(ppBase), .ppPowered(ppPowered),
      .ppPrinterMode(ppPrinterMode), .ppExtMode(ppExtMode), .cfgUnlocked(cfgUnlocked), .slotThree(slotThree),
      .slotFour(slotFour), .uartOne(uartOne), .uartTwo(uartTwo), .enhancedMode(enhancedMode),
      .interfaceStyle(interfaceStyle), .rateSel(rateSel), .ratePins(ratePins), .serialReqA(serialReqA),
      .serialReqB(serialReqB), .floppyReq(floppyReq), .parallelReq(parallelReq), .serialIrqA(serialIrqA),
      .serialIrqB(), .floppyIrq(floppyIrq), .parallelIrq(parallelIrq), .muxPinIn(muxPinIn),
      .extraAddrHit(extraAddrHit), .muxPin(muxPin), .driveTwoSense(driveTwoSense));

   ////////////////////////////////////////////////////////////////////////////
   // Comparison, verdict and expected UART base
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic close_out;
      $display("checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   function automatic logic [15:0] ub(input logic [1:0] c, input logic [1:0] sc);
      ub = (c == 2'h0) ? 16'h03F8 : (c == 2'h1) ? 16'h02F8 : (c == 2'h2) ? s3t[sc] : s4t[sc];
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Host port cycles: strobe held for exactly one taking edge
   task automatic wr(input logic [15:0] a, input logic [7:0] x);
      @(posedge clk);
      hostAddr <= a; hostWrData <= x; hostWrStb <= 1'b1;
      @(posedge clk);
      hostWrStb <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] idx, output logic [7:0] x);
      wr(16'h03F0, idx);
      @(posedge clk);
      hostAddr <= 16'h03F1; hostRdStb <= 1'b1;
      @(posedge clk);
      hostRdStb <= 1'b0;
      #1;
      chk(hostRdValid, 1'b1);
      x = hostRdData;
   endtask

   ////////////////////////////////////////////////////////////////////////////
   // Clock and cycle limit
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 8000) begin
         mismatches++;
         close_out();
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Main sequence
   initial begin
      {hardRst, cfgMode, hostWrStb, hostRdStb, serialReqA, serialReqB, floppyReq, parallelReq} = '0;
      {muxPinIn, extraAddrHit, hostAddr, hostWrData, ppExtMode, rateSel} = '0;
      sys_rst = 1'b1; ce = 1'b1; seed = 57; mismatches = 0; n_checks = 0; s = 8'hDC;
      repeat (6) @(posedge clk);
      sys_rst <= 1'b0; cfgMode <= 1'b1;
      // Power-up values and an unmapped index
      rd(8'h01, d); chk(d, 8'h9F);
      rd(8'h02, d); chk(d, 8'hDC);
      rd(8'h03, d); chk(d, 8'h78);
      rd(8'h04, d); chk(d, 8'h00);
      chk(uartTwo.base, 16'h02F8);
      // Every address code of the parallel, slot and primary UART fields; secondary UART codes are random
      for (i = 0; i < 16; i++) begin
         v = {1'b1, i[3:2], 2'h3, i[0], i[1:0]};
         s = $random(seed);
         s[1:0] = i[1:0];
         wr(16'h03F0, 8'h01); wr(16'h03F1, v); wr(16'h03F0, 8'h02); wr(16'h03F1, s);
         repeat (3) @(posedge clk);
         #1;
         chk(ppBase, ppt[i[1:0]]);
         chk(ppPowered, i[0]);
         chk({slotThree, slotFour}, {s3t[i[3:2]], s4t[i[3:2]]});
         chk(uartOne, {ub(s[1:0], i[3:2]), s[2], s[3]});
         chk(uartTwo, {ub(s[5:4], i[3:2]), s[6], s[7]});
         rd(8'h02, d); chk(d, s);
      end
      // Floppy options readback and rate pin mapping
      f = $random(seed);
      wr(16'h03F0, 8'h03); wr(16'h03F1, f);
      rd(8'h03, d); chk(d, f & 8'hFE);
      chk({enhancedMode, interfaceStyle}, {f[1], f[6:5]});
      for (j = 0; j < 4; j++) begin
         wr(16'h03F1, {3'h3, j == 2, j != 0, 1'b0, j == 3, 1'b0});
         for (k = 0; k < 4; k++) begin
            @(posedge clk) {rateSel, muxPinIn} <= {k[1:0], k[1]};
            repeat (4) @(posedge clk);
            #1;
            chk({muxPin, driveTwoSense}, {2'b00, k[1]});
            if (j == 2) chk(ratePins.pinOe, 2'h0);
            else chk(ratePins, {(j == 1) ? swp[k] : k[1:0], 2'h3});
         end
      end
      // Interrupt polarity, and the extended parallel mode override
      for (k = 0; k < 3; k++) begin
         wr(16'h03F0, 8'h01); wr(16'h03F1, {3'h4, k != 1, k != 2, 3'h7});
         @(posedge clk) ppExtMode <= (k == 2) ? 2'h1 : 2'h0;
         repeat (4) begin
            @(posedge clk) {floppyReq, parallelReq, serialReqA, serialReqB} <= $random(seed);
            repeat (3) @(posedge clk);
            #1;
            chk(floppyIrq, (k != 1) ? {floppyReq, 1'b1} : {1'b0, floppyReq});
            chk(parallelIrq, (k == 0) ? {parallelReq, 1'b1} : {1'b0, parallelReq});
            chk(serialIrqA, (k != 1) ? {serialReqA, 1'b1} : {1'b0, serialReqA});
            chk(ppPrinterMode, k != 2);
         end
      end
      // Access outside configuration mode is ignored
      @(posedge clk) cfgMode <= 1'b0;
      wr(16'h03F1, 8'h00);
      @(posedge clk) cfgMode <= 1'b1;
      rd(8'h01, d); chk(d, 8'h97);
      // Lock cleared blocks access until a hard reset
      wr(16'h03F1, 8'h1F);
      wr(16'h03F0, 8'h02); wr(16'h03F1, ~s);
      repeat (3) @(posedge clk);
      #1;
      chk(cfgUnlocked, 1'b0);
      rd(8'h02, d); chk(d, 8'h00);
      @(posedge clk) hardRst <= 1'b1;
      @(posedge clk) hardRst <= 1'b0;
      rd(8'h01, d); chk(d, 8'h9F);
      rd(8'h02, d); chk(d, s);
      // A write while the clock enable is low is frozen out
      @(posedge clk) ce <= 1'b0;
      wr(16'h03F1, 8'h00);
      @(posedge clk) ce <= 1'b1;
      rd(8'h02, d); chk(d, s);
      close_out();
   end
endmodule // tb_top
